// ---- lpwc_pkg.sv ----
/*
 * lpwc_pkg: constants shared by the low power wake control block.
 * assumes a single 10 MHz core clock and a synchronous active high reset.
 */
`default_nettype none

package lpwc_pkg;

   // ************************************************************
   // clocking
   // ************************************************************
   localparam int unsigned CORE_CLK_HZ = 10000000; // core clock rate
   localparam int unsigned WDT_CLK_HZ = 32768; // watchdog tick rate
   // core cycles per 32 kHz tick, rounded down
   localparam int unsigned WDT_DIV_CYC = CORE_CLK_HZ / WDT_CLK_HZ;
   localparam logic [8:0] WDT_DIV_LAST = 9'(WDT_DIV_CYC - 1);

   // pll lock wait after a wake, in microseconds and cycles
   localparam int unsigned PLL_LOCK_US = 100;
   localparam int unsigned PLL_LOCK_CYC = PLL_LOCK_US * (CORE_CLK_HZ / 1000000);
   localparam logic [11:0] PLL_LOCK_LAST = 12'(PLL_LOCK_CYC - 1);

   // reference clock range in MHz and multiplier selection bound
   localparam logic [5:0] REF_MHZ_MIN = 6'h06;
   localparam logic [5:0] REF_MHZ_MAX = 6'h28;
   localparam logic [5:0] REF_MHZ_MID = 6'h14;
   localparam logic [5:0] MAIN_MHZ = 6'h13; // 19.2 MHz main clock, integer part

   // pll multiply codes
   localparam logic [1:0] MUL_MAIN = 2'h0;
   localparam logic [1:0] MUL_REF_LO = 2'h1;
   localparam logic [1:0] MUL_REF_HI = 2'h2;

   // watchdog counter width and zero
   localparam logic [15:0] WDT_ZERO = 16'h0000;

   // ************************************************************
   // power states, one-hot
   // ************************************************************
   typedef enum logic [4:0] {
      LPWC_RUN = 5'h01, // normal mode, all clocks on
      LPWC_SUSP = 5'h02, // suspend, only phy clocked
      LPWC_STBY = 5'h04, // standby, pll and transceiver off
      LPWC_LOCK = 5'h08, // clocks restarted, waiting for lock
      LPWC_RST = 5'h10 // reset held on core
   } lpwc_state_e;

endpackage : lpwc_pkg

`default_nettype wire

// ---- lpwc_top.sv ----
/*
 * lpwc_top: power mode and wake control for the bridge device.
 * firmware asks for suspend or standby; usb line events, the flow control
 * input, the watchdog and the hard reset pin bring the device back.
 * assumes all inputs are synchronous to core_clk_i and that the 32 kHz
 * watchdog tick arrives as a one-cycle pulse or is made here by division.
 */
`default_nettype none

// Notes on behaviour
// - pll multiplier chosen from supplied input frequency
// - watchdog counts 32 kHz ticks, optional external
// - watchdog expiry interrupts, wakes standby, resets core
// - disabled watchdog gives no interrupt, wake, reset
// - normal mode keeps cpu clock and plls on
// - suspend puts phy in u3, stops other clocks
// - io pins hold prior level during suspend
// - registers and ram retained across suspend
// - wake on d plus, d minus, vbus events
// - wake on superspeed resume detection
// - wake on flow control level, programmable polarity
// - suspend wake resumes; hard reset pin resets
// - standby exit resets pc, keeps gpio setup
module lpwc_top (
   input wire logic core_clk_i, // core clock, 10 MHz
   input wire logic srst_i, // synchronous reset, active high
   input wire logic hard_rst_i, // hard reset pin, active high here
   input wire logic [5:0] reference_clock_input_mhz_i, // ref freq, MHz
   input wire logic use_reference_i, // pll runs from the reference clock
   input wire logic ext_32k_sel_i, // take watchdog tick from pin
   input wire logic ext_32k_tick_i, // external 32 kHz tick pulse
   input wire logic wdt_enable_i, // firmware watchdog enable
   input wire logic [15:0] wdt_reload_i, // watchdog period in ticks
   input wire logic wdt_kick_i, // firmware service pulse
   input wire logic susp_req_i, // firmware suspend request
   input wire logic stby_req_i, // firmware standby request
   input wire logic dp_i, // d plus line level
   input wire logic dm_i, // d minus line level
   input wire logic vbus_i, // vbus detected
   input wire logic ss_resume_i, // superspeed resume condition seen
   input wire logic cts_i, // flow control input
   input wire logic cts_pol_i, // level of cts that wakes
   input wire logic pll_lock_i, // pll lock indication
   input wire logic [11:0] io_level_i, // live io levels from the core
   output logic [1:0] pll_mul_o, // pll multiply selection
   output logic pll_en_o, // plls enabled
   output logic cpu_clk_en_o, // processor clock enabled
   output logic phy_u3_o, // usb 3.0 phy held in u3
   output logic xcvr_en_o, // usb transceiver on
   output logic io_hold_o, // io pads latch their level
   output logic [11:0] io_level_o, // io levels seen at the pads
   output logic ret_en_o, // memory and register retention
   output logic cpu_run_o, // core released to run
   output logic cpu_rst_o, // core reset pulse, pc reset
   output logic dev_rst_o, // whole device reset
   output logic wdt_irq_o, // watchdog interrupt pulse
   output logic [4:0] pwr_state_o // current power state
);

   // ************************************************************
   // state
   // ************************************************************
   lpwc_pkg::lpwc_state_e state_reg; // power state
   lpwc_pkg::lpwc_state_e state_next; // next power state
   logic from_stby_reg; // wake came out of standby
   logic [8:0] div_reg; // internal 32 kHz divider
   logic tick_reg; // one watchdog tick per pulse
   logic [15:0] wdt_reg; // watchdog down counter
   logic wdt_exp; // watchdog expiry this cycle
   logic [11:0] lock_reg; // pll lock wait counter
   logic dp_d_reg; // last d plus level
   logic dm_d_reg; // last d minus level
   logic wake; // any enabled wake source
   logic is_low; // device in a low power state

   // ************************************************************
   // pll multiply choice
   // ************************************************************
   // main clock is fixed; reference is split into two bands so the
   // internal rate does not follow the input frequency
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         pll_mul_o <= lpwc_pkg::MUL_MAIN;
      end else if (!use_reference_i) begin
         pll_mul_o <= lpwc_pkg::MUL_MAIN;
      end else if (reference_clock_input_mhz_i < lpwc_pkg::REF_MHZ_MID) begin
         pll_mul_o <= lpwc_pkg::MUL_REF_LO;
      end else begin
         pll_mul_o <= lpwc_pkg::MUL_REF_HI;
      end
   end

   // ************************************************************
   // watchdog tick source
   // ************************************************************
   // the internal divider is only an approximation of 32 kHz; a board
   // that needs accuracy should supply the tick on the pin
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         div_reg <= 9'h000;
         tick_reg <= 1'b0;
      end else if (ext_32k_sel_i) begin
         div_reg <= 9'h000;
         tick_reg <= ext_32k_tick_i;
      end else if (div_reg == lpwc_pkg::WDT_DIV_LAST) begin
         div_reg <= 9'h000;
         tick_reg <= 1'b1;
      end else begin
         div_reg <= div_reg + 9'h001;
         tick_reg <= 1'b0;
      end
   end

   // ************************************************************
   // watchdog counter
   // ************************************************************
   // expiry only when enabled and counted down on a tick
   assign wdt_exp = wdt_enable_i && tick_reg &&
                    (wdt_reg == 16'h0001);

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         wdt_reg <= 16'hffff;
      end else if (!wdt_enable_i || wdt_kick_i || wdt_exp) begin
         wdt_reg <= wdt_reload_i; // disabled, serviced or expired: reload
      end else if (tick_reg && wdt_reg != lpwc_pkg::WDT_ZERO) begin
         wdt_reg <= wdt_reg - 16'h0001;
      end
   end

   // interrupt pulse only while the core runs
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         wdt_irq_o <= 1'b0;
      end else begin
         wdt_irq_o <= wdt_exp && state_reg == lpwc_pkg::LPWC_RUN;
      end
   end

   // ************************************************************
   // wake sources
   // ************************************************************
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         dp_d_reg <= 1'b0;
         dm_d_reg <= 1'b0;
      end else begin
         dp_d_reg <= dp_i;
         dm_d_reg <= dm_i;
      end
   end

   assign is_low = state_reg == lpwc_pkg::LPWC_SUSP ||
                   state_reg == lpwc_pkg::LPWC_STBY;

   always_comb begin
      wake = (dp_i != dp_d_reg) ||
             (dm_d_reg && !dm_i) ||
             vbus_i ||
             ss_resume_i ||
             (cts_i == cts_pol_i);
      // watchdog wakes standby only
      if (state_reg == lpwc_pkg::LPWC_STBY && wdt_exp) begin
         wake = 1'b1;
      end
   end

   // ************************************************************
   // power state machine
   // ************************************************************
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         lpwc_pkg::LPWC_RUN: begin
            // firmware has drained traffic before asking
            if (wdt_exp) begin
               state_next = lpwc_pkg::LPWC_RST;
            end else if (stby_req_i) begin
               state_next = lpwc_pkg::LPWC_STBY;
            end else if (susp_req_i) begin
               state_next = lpwc_pkg::LPWC_SUSP;
            end
         end
         lpwc_pkg::LPWC_SUSP, lpwc_pkg::LPWC_STBY: begin
            if (wake) begin
               state_next = lpwc_pkg::LPWC_LOCK;
            end
         end
         lpwc_pkg::LPWC_LOCK: begin
            if (lock_reg == lpwc_pkg::PLL_LOCK_LAST && pll_lock_i) begin
               state_next = from_stby_reg ? lpwc_pkg::LPWC_RST
                                          : lpwc_pkg::LPWC_RUN;
            end
         end
         lpwc_pkg::LPWC_RST: begin
            state_next = lpwc_pkg::LPWC_RUN;
         end
         default: begin
            state_next = lpwc_pkg::LPWC_RUN;
         end
      endcase
   end

   // hard reset pin overrides every state and restarts the device
   always_ff @(posedge core_clk_i) begin
      if (srst_i || hard_rst_i) begin
         state_reg <= lpwc_pkg::LPWC_RUN;
      end else begin
         state_reg <= state_next;
      end
   end

   // remember where the wake came from
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         from_stby_reg <= 1'b0;
      end else if (state_reg == lpwc_pkg::LPWC_STBY) begin
         from_stby_reg <= 1'b1;
      end else if (state_reg == lpwc_pkg::LPWC_SUSP) begin
         from_stby_reg <= 1'b0;
      end
   end

   // lock wait: minimum settle time, then lock must be seen
   always_ff @(posedge core_clk_i) begin
      if (srst_i || state_reg != lpwc_pkg::LPWC_LOCK) begin
         lock_reg <= 12'h000;
      end else if (lock_reg != lpwc_pkg::PLL_LOCK_LAST) begin
         lock_reg <= lock_reg + 12'h001;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         pll_en_o <= 1'b1;
         cpu_clk_en_o <= 1'b1;
         phy_u3_o <= 1'b0;
         xcvr_en_o <= 1'b1;
         cpu_run_o <= 1'b0;
         ret_en_o <= 1'b0;
         pwr_state_o <= lpwc_pkg::LPWC_RUN;
      end else begin
         pll_en_o <= !is_low;
         cpu_clk_en_o <= state_reg == lpwc_pkg::LPWC_RUN;
         phy_u3_o <= state_reg == lpwc_pkg::LPWC_SUSP;
         xcvr_en_o <= state_reg != lpwc_pkg::LPWC_STBY;
         cpu_run_o <= state_reg == lpwc_pkg::LPWC_RUN;
         ret_en_o <= is_low;
         pwr_state_o <= state_reg;
      end
   end

   // pads freeze their level while in a low power state; gpio setup
   // stays because nothing here touches it
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         io_hold_o <= 1'b0;
         io_level_o <= 12'h000;
      end else begin
         io_hold_o <= is_low;
         if (!is_low) begin
            io_level_o <= io_level_i;
         end
      end
   end

   // reset pulses: core reset after standby or watchdog, device reset
   // on the hard reset pin
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         cpu_rst_o <= 1'b0;
         dev_rst_o <= 1'b0;
      end else begin
         cpu_rst_o <= state_reg == lpwc_pkg::LPWC_RST;
         dev_rst_o <= hard_rst_i;
      end
   end

endmodule : lpwc_top

`default_nettype wire

// ---- lpwc_pll_model.sv ----
/* lpwc_pll_model: behavioural pll lock seen by the wake control.
   assumes its enable comes from lpwc_top on the core clock. */
`default_nettype none
module lpwc_pll_model (
   input wire logic clk_i,
   input wire logic en_i,
   output logic lock_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [4:0] cnt_reg = 5'h00; // cycles since the pll was enabled
   // a real pll needs time to settle, so lock never follows enable at once
   always_ff @(posedge clk_i) begin
      if (!en_i) cnt_reg <= 5'h00;
      else if (cnt_reg != 5'h1f) cnt_reg <= cnt_reg + 5'h01;
   end
   assign lock_o = en_i && (cnt_reg == 5'h1f); // lock drops with enable
endmodule : lpwc_pll_model
`default_nettype wire

// ---- lpwc_top_props.sv ----
/* lpwc_top_props: power state assertions on the lpwc_top ports.
   assumes one core clock and the synchronous active high reset. */
`default_nettype none
module lpwc_top_props (
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic hard_rst_i,
   input wire logic susp_req_i,
   input wire logic stby_req_i,
   input wire logic wdt_enable_i,
   input wire logic vbus_i,
   input wire logic ss_resume_i,
   input wire logic cts_i,
   input wire logic cts_pol_i,
   input wire logic pll_lock_i,
   input wire logic pll_en_o,
   input wire logic cpu_clk_en_o,
   input wire logic phy_u3_o,
   input wire logic io_hold_o,
   input wire logic [11:0] io_level_o,
   input wire logic ret_en_o,
   input wire logic cpu_run_o,
   input wire logic dev_rst_o,
   input wire logic wdt_irq_o,
   input wire logic [4:0] pwr_state_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (srst_i);
   logic [10:0] lock_cnt; // cycles spent in the lock wait state
   // counts from zero on the first lock cycle, saturating
   always_ff @(posedge core_clk_i) begin
      if (srst_i || pwr_state_o != 5'h08) lock_cnt <= 11'h000;
      else if (lock_cnt != 11'h7ff) lock_cnt <= lock_cnt + 11'h001;
   end
   AST_RUN_CLK: assert property (
      pwr_state_o == 5'h01 |-> pll_en_o && cpu_clk_en_o)
      else $error("clocks off in normal mode");
   AST_SUSP_ENTRY: assert property (
      susp_req_i && !stby_req_i && !wdt_enable_i && !hard_rst_i
      ##1 pwr_state_o == 5'h01 |=> pwr_state_o == 5'h02)
      else $error("suspend request not taken");
   AST_NO_SELF_SUSP: assert property (
      !susp_req_i ##1 pwr_state_o == 5'h01 |=> pwr_state_o != 5'h02)
      else $error("suspend without request");
   AST_SUSP_OUT: assert property (
      pwr_state_o == 5'h02 |-> phy_u3_o && !cpu_clk_en_o && !pll_en_o
      && ret_en_o && io_hold_o && !cpu_run_o)
      else $error("suspend outputs wrong");
   AST_IO_HOLD: assert property (
      io_hold_o && $past(io_hold_o) |-> $stable(io_level_o))
      else $error("io level moved while held");
   AST_WAKE: assert property (
      pwr_state_o == 5'h02 && !hard_rst_i && !$past(hard_rst_i)
      && (vbus_i || ss_resume_i || cts_i == cts_pol_i)
      |-> ##2 pwr_state_o == 5'h08)
      else $error("wake event ignored");
   AST_LOCK_PLL: assert property (
      pwr_state_o == 5'h08 && !hard_rst_i && !$past(hard_rst_i)
      && !pll_lock_i |-> ##2 pwr_state_o == 5'h08)
      else $error("left lock wait without lock");
   AST_LOCK_WAIT: assert property (
      pwr_state_o == 5'h08 && !hard_rst_i && !$past(hard_rst_i)
      && lock_cnt < 11'h3e7 |=> pwr_state_o == 5'h08)
      else $error("lock wait too short");
   AST_HARD_RST: assert property (
      hard_rst_i |=> dev_rst_o ##1 pwr_state_o == 5'h01)
      else $error("hard reset not applied");
   AST_WDT_OFF: assert property (
      !wdt_enable_i [*3] |-> !wdt_irq_o)
      else $error("irq from disabled watchdog");
endmodule : lpwc_top_props
bind lpwc_top lpwc_top_props u_props (.core_clk_i, .srst_i, .hard_rst_i,
   .susp_req_i, .stby_req_i, .wdt_enable_i, .vbus_i, .ss_resume_i, .cts_i,
   .cts_pol_i, .pll_lock_i, .pll_en_o, .cpu_clk_en_o, .phy_u3_o, .io_hold_o,
   .io_level_o, .ret_en_o, .cpu_run_o, .dev_rst_o, .wdt_irq_o, .pwr_state_o);
`default_nettype wire

// ---- low_power_wake_control_tb_top.sv ----
/* low_power_wake_control_tb_top: directed bench for lpwc_top.
   assumes the package, design, pll model and checker compile first. */
`default_nettype none
module low_power_wake_control_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk_i = 1'b0, srst_i = 1'b1, hard_rst_i = 1'b0;
   logic use_reference_i = 1'b0, ext_32k_sel_i = 1'b1, ext_32k_tick_i = 1'b0;
   logic wdt_enable_i = 1'b0, wdt_kick_i = 1'b0, susp_req_i = 1'b0;
   logic stby_req_i = 1'b0, dp_i = 1'b0, dm_i = 1'b1, vbus_i = 1'b0;
   logic ss_resume_i = 1'b0, cts_i = 1'b0, cts_pol_i = 1'b1;
   logic [5:0] reference_clock_input_mhz_i = 6'h06;
   logic [15:0] wdt_reload_i = 16'h0004; // short period keeps runs brief
   logic [11:0] io_level_i = 12'ha5c;
   wire logic pll_lock_i;
   logic [1:0] pll_mul_o;
   logic pll_en_o, cpu_clk_en_o, phy_u3_o, xcvr_en_o, io_hold_o, ret_en_o;
   logic cpu_run_o, cpu_rst_o, dev_rst_o, wdt_irq_o;
   logic [11:0] io_level_o;
   logic [4:0] pwr_state_o;
   int failures = 0, comparisons = 0, cycles = 0, rst_seen = 0, irq_seen = 0;
   lpwc_top dut (.core_clk_i, .srst_i, .hard_rst_i,
      .reference_clock_input_mhz_i, .use_reference_i, .ext_32k_sel_i,
      .ext_32k_tick_i, .wdt_enable_i, .wdt_reload_i, .wdt_kick_i, .susp_req_i,
      .stby_req_i, .dp_i, .dm_i, .vbus_i, .ss_resume_i, .cts_i, .cts_pol_i,
      .pll_lock_i, .io_level_i, .pll_mul_o, .pll_en_o, .cpu_clk_en_o,
      .phy_u3_o, .xcvr_en_o, .io_hold_o, .io_level_o, .ret_en_o, .cpu_run_o,
      .cpu_rst_o, .dev_rst_o, .wdt_irq_o, .pwr_state_o);
   lpwc_pll_model u_pll (.clk_i(core_clk_i), .en_i(pll_en_o),
      .lock_o(pll_lock_i));
   always #50 core_clk_i = ~core_clk_i; // 10 MHz
   // pulse counting, external watchdog tick and the hang guard
   always @(negedge core_clk_i) begin
      cycles++;
      rst_seen += (cpu_rst_o === 1'b1);
      irq_seen += (wdt_irq_o === 1'b1);
      ext_32k_tick_i <= (cycles % 8 == 0);
      if (cycles == 30000) begin
         failures++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish;
      $display("failures=%0d comparisons=%0d", failures, comparisons);
      if (failures == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk_i);
   endtask : cyc
   task automatic wait_state(input logic [4:0] s);
      for (int i = 0; i < 1500 && pwr_state_o !== s; i++) cyc(1);
   endtask : wait_state
   task automatic enter_susp; // nothing outstanding when asked
      {dp_i, dm_i, vbus_i, ss_resume_i} = 4'h4;
      cts_i = ~cts_pol_i;
      io_level_i = 12'ha5c;
      cyc(1);
      susp_req_i = 1'b1;
      cyc(1);
      susp_req_i = 1'b0;
      cyc(2);
   endtask : enter_susp
   task automatic t_mul;
      logic [5:0] mhz [4];
      mhz = '{6'h06, 6'h13, 6'h14, 6'h28};
      use_reference_i = 1'b1;
      for (int k = 0; k < 4; k++) begin
         reference_clock_input_mhz_i = mhz[k];
         cyc(2);
         chk(pll_mul_o, (mhz[k] < lpwc_pkg::REF_MHZ_MID) ?
            lpwc_pkg::MUL_REF_LO : lpwc_pkg::MUL_REF_HI);
      end
      use_reference_i = 1'b0;
      cyc(2);
      chk(pll_mul_o, lpwc_pkg::MUL_MAIN);
   endtask : t_mul
   task automatic t_susp(input int src);
      int r0;
      cts_pol_i = (src != 5);
      enter_susp();
      chk({phy_u3_o, cpu_clk_en_o, pll_en_o, io_hold_o, ret_en_o, cpu_run_o,
         xcvr_en_o}, 16'h004d);
      io_level_i = 12'h3c3;
      cyc(4);
      chk(io_level_o, 16'h0a5c);
      chk(pwr_state_o, 16'h0002);
      r0 = rst_seen;
      case (src)
         0: dp_i = 1'b1;
         1: dm_i = 1'b0;
         2: vbus_i = 1'b1;
         3: ss_resume_i = 1'b1;
         default: cts_i = cts_pol_i;
      endcase
      cyc(2);
      chk({pwr_state_o, pll_en_o, cpu_run_o}, 16'h0022);
      wait_state(5'h01);
      cyc(1);
      chk({cpu_run_o, 5'(rst_seen - r0)}, 16'h0020);
   endtask : t_susp
   task automatic t_stby;
      int r0;
      r0 = rst_seen;
      cts_i = ~cts_pol_i;
      {wdt_enable_i, wdt_kick_i, stby_req_i} = 3'h7;
      cyc(1);
      {wdt_kick_i, stby_req_i} = 2'h0;
      cyc(2);
      chk({pwr_state_o, xcvr_en_o}, 16'h0008);
      wait_state(5'h08);
      wdt_enable_i = 1'b0;
      wait_state(5'h01);
      cyc(2);
      chk({pwr_state_o, 5'(rst_seen - r0)}, 16'h0021);
   endtask : t_stby
   task automatic t_wdt;
      int r0, r1;
      r0 = irq_seen;
      r1 = rst_seen;
      {wdt_enable_i, wdt_kick_i} = 2'h3;
      cyc(1);
      wdt_kick_i = 1'b0;
      cyc(60);
      wdt_enable_i = 1'b0;
      // one edge with the watchdog off, so no pulse races the snapshot
      cyc(1);
      chk({irq_seen != r0, rst_seen != r1}, 16'h0003);
      r0 = irq_seen;
      cyc(200);
      chk(5'(irq_seen - r0), 16'h0000);
      // internal divider: four ticks of 305 cycles before expiry
      ext_32k_sel_i = 1'b0;
      {wdt_enable_i, wdt_kick_i} = 2'h3;
      cyc(1);
      wdt_kick_i = 1'b0;
      cyc(1100);
      chk(5'(irq_seen - r0), 16'h0000);
      cyc(500);
      wdt_enable_i = 1'b0;
      cyc(1);
      chk(5'(irq_seen - r0), 16'h0001);
      ext_32k_sel_i = 1'b1;
   endtask : t_wdt
   task automatic t_hard;
      enter_susp();
      hard_rst_i = 1'b1;
      // state shows on the port one edge after the pin takes effect
      cyc(2);
      chk({dev_rst_o, pwr_state_o}, 16'h0021);
      hard_rst_i = 1'b0;
      cyc(3);
      chk({dev_rst_o, cpu_run_o, io_hold_o}, 16'h0002);
   endtask : t_hard
   initial begin
      cyc(3);
      srst_i = 1'b0;
      cyc(2);
      chk({pwr_state_o, pll_en_o, cpu_clk_en_o, cpu_run_o}, 16'h000f);
      t_mul();
      for (int s = 0; s < 6; s++) t_susp(s);
      t_stby();
      t_wdt();
      t_hard();
      tally_and_finish();
   end
endmodule : low_power_wake_control_tb_top
`default_nettype wire
